// *** pkg/omwc_pkg.sv ***
`default_nettype none
package omwc_pkg;
  // register byte addresses
  localparam logic [7:0] OMWC_ADR_MODE = 8'h00;
  localparam logic [7:0] OMWC_ADR_CTRL = 8'h04;
  localparam logic [7:0] OMWC_ADR_STAT = 8'h08;
  localparam logic [7:0] OMWC_ADR_PORTA_WAKE_ENABLE = 8'h0c;
  // mode and control register fields
  localparam int OMWC_FSS_BIT   = 0;
  localparam int OMWC_IDLE_BIT  = 1;
  localparam int OMWC_FRDY_BIT  = 2;
  localparam int OMWC_SRDY_BIT  = 3;
  localparam int OMWC_FAST_WAKEUP_ENABLE_BIT = 4;
  localparam int OMWC_DIV_LSB   = 5;
  localparam int OMWC_KEEP_BIT  = 7;
  localparam logic [2:0] OMWC_DIV_SLOW_MAX = 3'h1;
  // values after reset
  localparam logic [7:0] OMWC_MODE_RST = 8'h03;
  localparam logic       OMWC_KEEP_RST = 1'b0;
  localparam logic [7:0] OMWC_PORTA_WAKE_ENABLE_RST = 8'h00;
  // oscillator start-up counts, in clock cycles
  localparam logic [7:0] OMWC_XTAL_CYC = 8'h80;
  localparam logic [7:0] OMWC_RC_CYC   = 8'h10;
  localparam logic [7:0] OMWC_SLOW_CYC = 8'h02;

  typedef enum logic [1:0] {
    LP_DEEP, LP_LIGHT, LP_IDLE_STOP, LP_IDLE_RUN
  } omwc_lp_t;

  typedef enum logic [1:0] {ST_RUN, ST_LP, ST_WAKE} omwc_state_t;

  // clock and oscillator enables
  typedef struct packed {
    logic sys;
    logic timebase;
    logic sub;
    logic wdt;
    logic fast_osc;
    logic fast_div;
  } omwc_clk_t;

  // latched wake-up cause
  typedef struct packed {
    logic ext_rst;
    logic porta;
    logic irq;
    logic wdt;
  } omwc_wake_t;
endpackage
`default_nettype wire

// *** testbench/omwc_cpu_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module omwc_cpu_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic go_i,
  input  wire logic run_i,
  output logic      halt_o
);
  // one halt pulse per request, only while executing
  always_ff @(posedge clk_i) begin
    halt_o <= go_i && run_i && !halt_o && !rst_i;
  end
endmodule
`default_nettype wire

// *** testbench/operating_mode_wakeup_control_bench.sv ***
`timescale 1ns/10ps
`default_nettype none
module operating_mode_wakeup_control_bench
  import omwc_pkg::*;
;
  logic        clk_i, rst_i, cyc, stb, we, halt, clr, wen, lven, ovf, go;
  logic        ack, run, sub, hold;
  logic        crystal, ext, sfull;
  // wdt clear, wake, full reset, pc/sp reset, irq take
  logic [4:0]  pulse;
  int          npulse [5];
  localparam int NPULSE [5] = '{6, 6, 1, 1, 1};
  logic [7:0]  adr, porta;
  logic [31:0] dat, rdat, q;
  logic [3:0]  sel, irq, ien;
  omwc_clk_t   ck;
  int          num_errors, checked, i, n;
  // {run, hold, sys, timebase, sub} per low-power mode
  localparam logic [4:0] LPCLK [4] = '{5'h08, 5'h01, 5'h03, 5'h07};
  localparam logic [3:0] CAUSE [4] = '{4'h4, 4'h2, 4'h1, 4'h4};
  localparam logic [7:0] ZADR  [3] = '{OMWC_ADR_CTRL, OMWC_ADR_PORTA_WAKE_ENABLE, 8'h10};
  localparam logic [7:0] SMODE [4] = '{8'h20, 8'h40, 8'h00, 8'he0};

  omwc_core uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
    .wb_dat_o(rdat), .wb_ack_o(ack), .halt_i(halt), .clr_wdt_i(clr),
    .wdt_en_i(wen), .lvd_en_i(lven), .crystal_i(crystal),
    .ext_reset_i(ext), .wdt_ovf_i(ovf), .porta_i(porta),
    .irq_req_i(irq), .irq_en_i(ien), .stack_full_i(sfull), .clk_o(ck),
    .cpu_run_o(run), .on_sub_o(sub), .wdt_clr_o(pulse[0]),
    .wdt_hold_o(hold), .wake_o(pulse[1]), .full_reset_o(pulse[2]),
    .pc_sp_reset_o(pulse[3]), .irq_take_o(pulse[4])
  );

  // count each one-cycle pulse the design gives
  always @(posedge clk_i) begin
    for (int k = 0; k < 5; k++) begin
      if (pulse[k] === 1'b1) npulse[k]++;
    end
  end
  omwc_cpu_model cpu (
    .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .run_i(run), .halt_o(halt)
  );

  // classic wishbone single cycle, held until ack
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk_i);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    do @(posedge clk_i); while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'b00;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask

  // read mode register until a ready bit is set
  task automatic poll(input int b);
    q = '0;
    while (q[b] !== 1'b1) wb(1'b0, OMWC_ADR_MODE, '0);
  endtask

  task automatic do_halt();
    @(posedge clk_i);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic summarize();
    if (num_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // 10 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // hang guard
  initial begin
    #2000000;
    num_errors++;
    summarize();
  end

  initial begin
    {rst_i, cyc, stb, we, clr, wen, lven, ovf, go} = 9'h100;
    {crystal, ext, sfull} = 3'h0;
    {adr, dat, irq} = '0;
    {sel, ien, porta} = 16'hffff;
    num_errors = 0;
    checked = 0;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, OMWC_ADR_MODE, '0);
    chk(q, 32'(OMWC_MODE_RST));
    for (i = 0; i < 3; i++) begin
      wb(1'b0, ZADR[i], '0);
      chk(q, '0);
    end
    poll(OMWC_FRDY_BIT);
    chk(q & 32'h7, 32'h7);
    wb(1'b1, OMWC_ADR_PORTA_WAKE_ENABLE, 32'h1);
    // each low-power mode; deep and running idle woken by port A, light by irq, stopped idle by watchdog
    for (i = 0; i < 4; i++) begin
      wb(1'b1, OMWC_ADR_MODE, 32'(i < 2 ? 1 : 3));
      wb(1'b1, OMWC_ADR_CTRL, (i == 3) ? 32'h80 : 32'h0);
      wen <= (i == 2);
      lven <= (i == 1);
      irq <= (i == 1) ? 4'h2 : 4'h0; // pending before entry
      do_halt();
      chk(32'({run, hold, ck[5:3]}), 32'(LPCLK[i]));
      wb(1'b0, OMWC_ADR_STAT, '0);
      chk(q & 32'h1f, 32'(17 + 4 * i));
      repeat (5) @(posedge clk_i);
      chk(32'(run), 32'h0);
      case (i)
        1: irq <= 4'h3;
        2: ovf <= 1'b1;
        default: porta <= 8'hfe;
      endcase
      @(posedge clk_i);
      ovf <= 1'b0;
      while (run !== 1'b1) @(posedge clk_i);
      wb(1'b0, OMWC_ADR_STAT, '0);
      chk(q & 32'h1f3, 32'({CAUSE[i], 3'h0, i == 2, 1'b1}));
      wb(1'b0, OMWC_ADR_MODE, '0);
      chk(32'(q[OMWC_FRDY_BIT]), 32'h1);
      porta <= 8'hff;
      irq <= 4'h0;
    end
    {wen, lven} <= 2'b00;
    @(posedge clk_i);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    wb(1'b0, OMWC_ADR_STAT, '0);
    chk(q & 32'h1, 32'h0);
    // divider boundaries: 001 slow, 010 fast, 000 slow, 111 fast
    for (i = 0; i < 4; i++) begin
      wb(1'b1, OMWC_ADR_MODE, 32'(SMODE[i]));
      poll(i[0] ? OMWC_FRDY_BIT : OMWC_SRDY_BIT);
      n = 0;
      while (sub !== !i[0] && n < 50) begin
        @(posedge clk_i);
        n++;
      end
      chk(32'({sub, ck[1:0]}), i[0] ? 32'h3 : 32'h4);
    end
    // crystal with fast wake-up: light sleep resumes on sub clock
    {crystal, lven} <= 2'b11;
    wb(1'b1, OMWC_ADR_MODE, 32'h11);
    do_halt();
    {irq, sfull} <= 5'h03;
    repeat (2) @(posedge clk_i);
    chk(32'({run, sub}), 32'h3);
    n = 0;
    while (sub !== 1'b0 && n < 300) begin
      @(posedge clk_i);
      n++;
    end
    chk(n, 32'(OMWC_XTAL_CYC));
    @(posedge clk_i);
    chk(32'({run, sub}), 32'h2);
    {irq, sfull} <= 5'h00;
    wb(1'b0, OMWC_ADR_STAT, '0);
    chk(q & 32'h1e0, 32'h40);
    // running idle woken by external reset
    wb(1'b1, OMWC_ADR_MODE, 32'h13);
    do_halt();
    ext <= 1'b1;
    @(posedge clk_i);
    ext <= 1'b0;
    while (run !== 1'b1) @(posedge clk_i);
    wb(1'b0, OMWC_ADR_STAT, '0);
    chk(q & 32'h1e0, 32'h100);
    for (i = 0; i < 5; i++) begin
      chk(npulse[i], NPULSE[i]);
    end
    summarize();
  end
endmodule
`default_nettype wire

// *** verilog/omwc_core.sv ***
// Function
// R1 - divider 000/001 with select clear: slow mode
// R2 - select set or divider 010-111: fast clock
// R3 - slow source stops fast oscillator and dividers
// R4 - slow switch waits for slow ready flag
// R5 - software polls fast ready after leaving slow
// R6 - halt, no idle, no watchdog/detector: deep sleep
// R7 - halt, no idle, watchdog/detector on: light sleep
// R8 - halt, idle, no clock keep: stopped idle
// R9 - halt, idle, clock keep: running idle
// R10 - sleep halts execution, state kept
// R11 - entry sets power-down, clears timeout flag
// R12 - watchdog cleared on entry, then counts
// R13 - four wake sources end low power
// R14 - reset wake resets all; watchdog wake resets
// R15 - power-down cleared by clear, set by halt
// R16 - watchdog wake sets timeout, resets pc/sp
// R17 - enabled port pin falling edge wakes
// R18 - disabled irq or full stack: resume only
// R19 - irq pending at entry cannot wake
// R20 - one start-up timer, fast before slow
// R21 - deep wake waits for fast ready
// R22 - light wake may run on slow oscillator
// R23 - sub clock until 128 crystal cycles
// R24 - fast ready after 128 or 16 cycles
// R25 - low-power mode chosen at halt
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none
module omwc_core
  import omwc_pkg::*;
#(
  parameter int         NIRQ      = 4,
  parameter int         NPA       = 8,
  parameter logic [7:0] XTAL_CNT  = OMWC_XTAL_CYC,
  parameter logic [7:0] RC_CNT    = OMWC_RC_CYC,
  parameter logic [7:0] SLOW_CNT  = OMWC_SLOW_CYC
) (
  input  wire logic            clk_i,
  input  wire logic            rst_i,
  input  wire logic            wb_cyc_i,
  input  wire logic            wb_stb_i,
  input  wire logic            wb_we_i,
  input  wire logic [7:0]      wb_adr_i,
  input  wire logic [31:0]     wb_dat_i,
  input  wire logic [3:0]      wb_sel_i,
  output logic      [31:0]     wb_dat_o,
  output logic                 wb_ack_o,
  input  wire logic            halt_i,
  input  wire logic            clr_wdt_i,
  input  wire logic            wdt_en_i,
  input  wire logic            lvd_en_i,
  input  wire logic            crystal_i,
  input  wire logic            ext_reset_i,
  input  wire logic            wdt_ovf_i,
  input  wire logic [NPA-1:0]  porta_i,
  input  wire logic [NIRQ-1:0] irq_req_i,
  input  wire logic [NIRQ-1:0] irq_en_i,
  input  wire logic            stack_full_i,
  output omwc_clk_t            clk_o,
  output logic                 cpu_run_o,
  output logic                 on_sub_o,
  output logic                 wdt_clr_o,
  output logic                 wdt_hold_o,
  output logic                 wake_o,
  output logic                 full_reset_o,
  output logic                 pc_sp_reset_o,
  output logic                 irq_take_o
);
  logic [7:0]     mode_q;
  logic           keep_q;
  logic [NPA-1:0] porta_wake_enable_q;
  logic           ack_q;
  logic [31:0]    rd_q;
  omwc_state_t    st_q;
  omwc_lp_t       lp_q;
  omwc_lp_t       lp_sel;
  omwc_wake_t     cause_q;
  omwc_wake_t     wk;
  logic [NIRQ-1:0] irq_blk_q;
  logic [NPA-1:0] porta_q;
  logic [7:0]     sst_q;
  logic           sst_fast_q;
  logic           frdy_q;
  logic           srdy_q;
  logic           src_slow_q;
  logic           pdf_q;
  logic           to_q;
  logic           take_q;
  logic           wclr_q;
  logic           full_q;
  logic           pcsp_q;
  logic           wake_q;
  logic           itake_q;
  logic [7:0]     fon_cnt_q;

  logic       fss, idle_en, fast_wakeup_enable, slow_req, halt_go, lp_act, deep_act;
  logic       fast_on, slow_on, sub_run, tgt_rdy, wake_any, bus_go;
  logic [2:0] div;
  logic [7:0] fcnt;
  logic [NIRQ-1:0] irq_wk;

  // mode field decode
  assign fss      = mode_q[OMWC_FSS_BIT];
  assign idle_en  = mode_q[OMWC_IDLE_BIT];
  assign fast_wakeup_enable    = mode_q[OMWC_FAST_WAKEUP_ENABLE_BIT];
  assign div      = mode_q[OMWC_DIV_LSB +: 3];
  assign slow_req = ~fss & (div <= OMWC_DIV_SLOW_MAX); // R1 R2
  assign bus_go   = wb_cyc_i & wb_stb_i & ~ack_q;

  // low-power mode choice at halt
  always_comb begin
    if (!idle_en) begin
      lp_sel = (wdt_en_i | lvd_en_i) ? LP_LIGHT : LP_DEEP; // R6 R7 R25
    end else begin
      lp_sel = keep_q ? LP_IDLE_RUN : LP_IDLE_STOP; // R8 R9 R25
    end
  end

  assign halt_go  = (st_q == ST_RUN) & halt_i;
  assign lp_act   = (st_q == ST_LP);
  assign deep_act = lp_act & (lp_q == LP_DEEP);

  // oscillator enables
  assign fast_on = ~(src_slow_q & slow_req)
                 & ~(lp_act & (lp_q != LP_IDLE_RUN)); // R3
  assign slow_on = ~deep_act & (slow_req | src_slow_q | wdt_en_i
                 | lvd_en_i | lp_act | (crystal_i & fast_wakeup_enable));
  assign fcnt    = crystal_i ? XTAL_CNT : RC_CNT; // R24

  // wake sources; irqs pending at entry are masked
  assign irq_wk     = irq_req_i & ~irq_blk_q; // R19
  assign wk.ext_rst = ext_reset_i;
  assign wk.porta   = |(porta_wake_enable_q & porta_q & ~porta_i); // R17
  assign wk.irq     = |irq_wk;
  assign wk.wdt     = wdt_ovf_i & wdt_en_i & (lp_q != LP_DEEP);
  assign wake_any   = lp_act & (|wk); // R13

  // resume conditions; crystal fast wake-up from light sleep or stopped idle runs on sub clock
  assign tgt_rdy = src_slow_q ? srdy_q : frdy_q; // R21
  assign sub_run = (st_q == ST_WAKE) & ~src_slow_q & crystal_i & fast_wakeup_enable
                 & srdy_q & ~frdy_q
                 & ((lp_q == LP_LIGHT) | (lp_q == LP_IDLE_STOP)); // R22 R23
  assign cpu_run_o = (st_q == ST_RUN) | sub_run; // R10 R21
  assign on_sub_o  = sub_run | (st_q == ST_RUN & src_slow_q);

  // clock gating
  always_comb begin
    clk_o.sys      = ~(lp_act & (lp_q != LP_IDLE_RUN)); // R6 R8 R9
    clk_o.timebase = ~(lp_act & ((lp_q == LP_DEEP)
                   | (lp_q == LP_LIGHT))); // R7
    clk_o.sub      = slow_on; // R7 R8
    clk_o.wdt      = wdt_en_i & ~deep_act; // R6 R12
    clk_o.fast_osc = fast_on; // R3
    clk_o.fast_div = fast_on; // R3
  end
  assign wdt_hold_o = deep_act; // R6

  // wishbone register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_q <= OMWC_MODE_RST;
      keep_q <= OMWC_KEEP_RST;
      porta_wake_enable_q <= NPA'(OMWC_PORTA_WAKE_ENABLE_RST);
    end else if (bus_go & wb_we_i & wb_sel_i[0]) begin
      unique case (wb_adr_i)
        OMWC_ADR_MODE: mode_q <= wb_dat_i[7:0];
        OMWC_ADR_CTRL: keep_q <= wb_dat_i[OMWC_KEEP_BIT];
        OMWC_ADR_PORTA_WAKE_ENABLE: porta_wake_enable_q <= wb_dat_i[NPA-1:0];
        default: ;
      endcase
    end
  end

  // wishbone ack and read data
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      rd_q  <= 32'h0000_0000;
    end else begin
      ack_q <= bus_go;
      rd_q  <= 32'h0000_0000;
      if (bus_go & ~wb_we_i) begin
        unique case (wb_adr_i)
          OMWC_ADR_MODE: rd_q <= {24'h00_0000, mode_q[7:4], srdy_q,
                                  frdy_q, mode_q[1:0]}; // R4 R5
          OMWC_ADR_CTRL: rd_q <= {24'h00_0000, keep_q, 7'h00};
          OMWC_ADR_STAT: rd_q <= {23'h00_0000, cause_q, lp_act,
                                  lp_q, to_q, pdf_q};
          OMWC_ADR_PORTA_WAKE_ENABLE: rd_q <= {{(32-NPA){1'b0}}, porta_wake_enable_q};
          default: rd_q <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rd_q;

  // shared start-up timer, fast oscillator first
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sst_q      <= 8'h00;
      sst_fast_q <= 1'b0;
      frdy_q     <= 1'b0;
      srdy_q     <= 1'b0;
    end else begin
      if (!fast_on) frdy_q <= 1'b0;
      if (!slow_on) srdy_q <= 1'b0;
      if (fast_on & ~frdy_q) begin // R20
        sst_fast_q <= 1'b1;
        if (sst_fast_q & (sst_q == fcnt - 8'h01)) begin
          frdy_q <= 1'b1; // R24
          sst_q  <= 8'h00;
        end else begin
          sst_q <= sst_fast_q ? sst_q + 8'h01 : 8'h01;
        end
      end else if (slow_on & ~srdy_q) begin // R20
        // a count left over from the fast phase restarts at one
        sst_fast_q <= 1'b0;
        if (~sst_fast_q & (sst_q == SLOW_CNT - 8'h01)) begin
          srdy_q <= 1'b1; // R4
          sst_q  <= 8'h00;
        end else begin
          sst_q <= sst_fast_q ? 8'h01 : sst_q + 8'h01;
        end
      end else begin
        sst_fast_q <= 1'b0;
        sst_q      <= 8'h00;
      end
    end
  end

  // system clock source follows request once target is ready
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_slow_q <= 1'b0;
    end else if (slow_req & srdy_q) begin
      src_slow_q <= 1'b1; // R1 R4
    end else if (~slow_req & frdy_q) begin
      src_slow_q <= 1'b0; // R2
    end
  end

  // operating state machine
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_q      <= ST_RUN;
      lp_q      <= LP_DEEP;
      irq_blk_q <= '0;
      cause_q   <= '0;
      take_q    <= 1'b0;
    end else begin
      unique case (st_q)
        ST_RUN: if (halt_i) begin
          st_q      <= ST_LP; // R10
          lp_q      <= lp_sel; // R25
          irq_blk_q <= irq_req_i; // R19
        end
        ST_LP: if (wake_any) begin
          st_q    <= ST_WAKE; // R13
          cause_q <= wk;
          take_q  <= |(irq_wk & irq_en_i) & ~stack_full_i; // R18
        end
        ST_WAKE: if (tgt_rdy) begin
          st_q <= ST_RUN; // R21 R23
        end
      endcase
    end
  end

  // power-down and timeout flags; set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pdf_q <= 1'b0;
      to_q  <= 1'b0;
    end else begin
      if (halt_go) pdf_q <= 1'b1; // R11 R15
      else if (clr_wdt_i) pdf_q <= 1'b0; // R15
      if (wdt_ovf_i) to_q <= 1'b1; // R16
      else if (halt_go | clr_wdt_i) to_q <= 1'b0; // R11
    end
  end

  // event pulses toward cpu, watchdog and reset logic
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      porta_q <= '0;
      wclr_q  <= 1'b0;
      wake_q  <= 1'b0;
      full_q  <= 1'b0;
      pcsp_q  <= 1'b0;
      itake_q <= 1'b0;
    end else begin
      porta_q <= porta_i;
      wclr_q  <= halt_go; // R6 R12
      wake_q  <= wake_any;
      full_q  <= wake_any & wk.ext_rst; // R14
      pcsp_q  <= wake_any & ~wk.ext_rst & wk.wdt; // R14 R16
      itake_q <= (st_q == ST_WAKE) & tgt_rdy & take_q; // R18
    end
  end
  assign wdt_clr_o     = wclr_q;
  assign wake_o        = wake_q;
  assign full_reset_o  = full_q;
  assign pc_sp_reset_o = pcsp_q;
  assign irq_take_o    = itake_q;

  // cycles the fast oscillator has been starting
  always_ff @(posedge clk_i) begin
    if (rst_i | ~fast_on | frdy_q) fon_cnt_q <= 8'h00;
    else fon_cnt_q <= fon_cnt_q + 8'h01;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_halt_flags: assert property ((halt_go && !wdt_ovf_i) |=> // R11
    (pdf_q && !to_q)) else $error("halt did not set flags");
  a_clr_pdf: assert property ((clr_wdt_i && !halt_go) |=> // R15
    !pdf_q) else $error("clear did not drop power-down flag");
  a_deep_entry: assert property ((halt_go && !idle_en && // R6
    !wdt_en_i && !lvd_en_i) |=> (lp_q == LP_DEEP && !clk_o.sys
    && !clk_o.wdt && wdt_hold_o && wdt_clr_o))
    else $error("deep sleep entry wrong");
  a_light_entry: assert property ((halt_go && !idle_en && // R7
    (wdt_en_i || lvd_en_i)) |=> (lp_q == LP_LIGHT && !clk_o.timebase
    && clk_o.sub)) else $error("light sleep entry wrong");
  a_idle_stop: assert property ((halt_go && idle_en && // R8
    !keep_q) |=> (!clk_o.sys && clk_o.timebase && clk_o.sub))
    else $error("stopped idle entry wrong");
  a_idle_run: assert property ((halt_go && idle_en && // R9
    keep_q) |=> (clk_o.sys && clk_o.timebase && !cpu_run_o))
    else $error("running idle entry wrong");
  a_slow_stops: assert property ((src_slow_q && slow_req) |-> // R3
    (!clk_o.fast_osc && !clk_o.fast_div))
    else $error("fast clock runs in slow mode");
  a_slow_ready: assert property ($rose(src_slow_q) |-> // R4
    $past(srdy_q)) else $error("slow switch before ready");
  a_sst_order: assert property ($rose(srdy_q) |-> // R20
    ($past(frdy_q) || !$past(fast_on)))
    else $error("slow used timer first");
  a_rc_time: assert property (($rose(frdy_q) && !crystal_i) |-> // R24
    fon_cnt_q == RC_CNT) else $error("fast rc ready time wrong");
  a_xtal_time: assert property (($rose(frdy_q) && crystal_i) |-> // R23
    fon_cnt_q == XTAL_CNT) else $error("crystal ready time wrong");
  a_deep_wait: assert property ((st_q == ST_WAKE && // R21
    lp_q == LP_DEEP && !src_slow_q && !frdy_q) |-> !cpu_run_o)
    else $error("cpu ran before fast ready");
  a_wdt_wake: assert property ((wake_any && wk.wdt && // R16
    !wk.ext_rst) |=> (to_q && pc_sp_reset_o && st_q == ST_WAKE))
    else $error("watchdog wake wrong");
  a_irq_blocked: assert property ((lp_act && !ext_reset_i && // R19
    !wk.porta && !wk.wdt && (irq_req_i & ~irq_blk_q) == '0)
    |=> st_q == ST_LP) else $error("blocked irq woke device");

  // wake-up pulses and their causes
  a_wake_pulse: assert property (wake_any |=> // R13
    (wake_o && st_q == ST_WAKE)) else $error("wake pulse missing");
  a_porta_wake: assert property ((wake_any && wk.porta) |=> // R17
    (wake_o && cause_q.porta)) else $error("port wake cause wrong");
  a_ext_reset: assert property ((wake_any && wk.ext_rst) |=> // R14
    (full_reset_o && !pc_sp_reset_o)) else $error("reset wake wrong");
  a_full_stack: assert property ((wake_any && stack_full_i) |=> // R18
    !take_q) else $error("irq taken with full stack");

  c_deep_wake: cover property (deep_act ##1 wake_any ##[1:200]
    (st_q == ST_RUN));
  c_sub_run: cover property (sub_run ##[1:200] (st_q == ST_RUN));
  c_irq_take: cover property (irq_take_o);
  c_slow_mode: cover property ($rose(src_slow_q));
  c_ext_wake: cover property (full_reset_o);
endmodule
`default_nettype wire
